// *** inc/rscl_pkg.sv ***
// Constants, field layouts and types for the reset strap configuration loader.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock domain.
package rscl_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [3:0] RSCL_OFS_CTRL = 4'h0;
    localparam logic [3:0] RSCL_OFS_ADV = 4'h4;
    localparam logic [3:0] RSCL_OFS_SPECIAL = 4'h8;
    localparam logic [3:0] RSCL_OFS_STRAP = 4'hC;

    // Control register field positions.
    localparam int RSCL_CTRL_SOFT_RESET = 15;
    localparam int RSCL_CTRL_SPEED = 13;
    localparam int RSCL_CTRL_AN_EN = 12;
    localparam int RSCL_CTRL_PDOWN = 11;
    localparam int RSCL_CTRL_BIT10 = 10;
    localparam int RSCL_CTRL_DUPLEX = 8;

    // Advertisement field occupies bits 8 down to 5.
    localparam int RSCL_ADV_LSB = 5;

    // Special modes register field positions.
    localparam int RSCL_SPC_IF_KIND = 14;
    localparam int RSCL_SPC_MODE_LSB = 5;

    // Strap status register field positions.
    localparam int RSCL_STS_MODE_LSB = 0;
    localparam int RSCL_STS_RMII = 3;
    localparam int RSCL_STS_REG_OFF = 4;
    localparam int RSCL_STS_POR_DONE = 5;
    localparam int RSCL_STS_CRS_TX = 6;
    localparam int RSCL_STS_REPEATER = 7;

    // Mode strap codes.
    localparam logic [2:0] RSCL_M_10_HALF = 3'h0;
    localparam logic [2:0] RSCL_M_10_FULL = 3'h1;
    localparam logic [2:0] RSCL_M_100_HALF = 3'h2;
    localparam logic [2:0] RSCL_M_100_FULL = 3'h3;
    localparam logic [2:0] RSCL_M_AN_100H = 3'h4;
    localparam logic [2:0] RSCL_M_REPEATER = 3'h5;
    localparam logic [2:0] RSCL_M_PDOWN = 3'h6;
    localparam logic [2:0] RSCL_M_ALL = 3'h7;

    // Control bit patterns in the order speed, an_en, bit10, duplex, then advertisement field patterns.
    localparam logic [3:0] RSCL_C_0000 = 4'h0;
    localparam logic [3:0] RSCL_C_0001 = 4'h1;
    localparam logic [3:0] RSCL_C_1000 = 4'h8;
    localparam logic [3:0] RSCL_C_1001 = 4'h9;
    localparam logic [3:0] RSCL_C_1100 = 4'hC;
    localparam logic [3:0] RSCL_C_X10X = 4'hD;
    localparam logic [3:0] RSCL_A_0100 = 4'h4;
    localparam logic [3:0] RSCL_A_1111 = 4'hF;
    localparam logic [3:0] RSCL_A_NONE = 4'h0;

    // AXI responses.
    localparam logic [1:0] RSCL_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSCL_RESP_SLVERR = 2'h2;

    // Configuration that steers the 10/100 block.
    typedef struct packed {
        logic speed_100;
        logic an_enable;
        logic bit10;
        logic full_duplex;
        logic power_down;
        logic [3:0] advertise;
        logic crs_on_tx;
        logic repeater;
    } rscl_cfg_t;

endpackage

// *** hw/rscl_top.sv ***
// Reset strap configuration loader: samples mode, interface and regulator
// straps at reset and keeps the resulting configuration in AXI registers.
// Assumes all pin inputs are synchronous to mclk and sys_rst is power-on.
//
// Operation
// - at hard reset release load control and advertisement bits from mode strap.
// - soft reset reconfigures from present registers and ignores the mode strap.
// - code 000 gives 10 half 0000, code 001 gives 10 full 0001.
// - code 010 gives 1000 with carrier on tx, 011 gives 1001 receive only.
// - code 100 gives 1100, advertise 0100, carrier on transmit and receive.
// - code 101 gives repeater, 1100, advertise 0100, carrier on receive only.
// - code 111 gives control X10X and advertisement 1111.
// - code 110 comes up in power-down and is not a usable link.
// - manager writes override strap defaults and are used in their place.
// - interface strap latched as reset rises; low MII, high RMII.
// - at hard reset release interface-kind bit loads from interface strap.
// - at power-on with supplies valid, high regulator strap keeps regulator off.
// - low regulator strap at power-on switches the core regulator on.
// - mode straps share receive data and collision pins, sampled during reset.
// - mode and interface straps are captured at power-on reset and at hardware reset pin.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module rscl_top
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hard_reset_n,
    input wire logic supplies_valid,
    input wire logic [2:0] mode_pin_in,
    output logic [2:0] mode_pin_out,
    output logic [2:0] mode_pin_oe_n,
    input wire logic [2:0] rx_func_data,
    input wire logic reduced_if_select_strap,
    input wire logic core_regulator_off_strap,
    output logic core_regulator_en,
    output logic mac_if_kind_bit,
    output rscl_pkg::rscl_cfg_t block_cfg,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rscl_pkg::*;

    typedef enum {ST_RESET, ST_RELEASE, ST_RUN} rscl_phase_t;
    logic in_reset;
    rscl_phase_t phase_q;
    logic [2:0] strap_mode_q;
    logic strap_rmii_q, reg_off_q, por_pend_q;
    rscl_cfg_t cfg_q, strap_cfg;
    logic [2:0] spc_mode_q;
    logic if_kind_q, soft_pend_q;
    logic aw_got_q, w_got_q;
    logic [3:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [31:0] ctrl_word, adv_word, spc_word, sts_word;
    logic [31:0] wr_ctrl, wr_adv, wr_spc;

    // Decodes a mode strap code into the default configuration.
    function automatic rscl_cfg_t mode_decode(input logic [2:0] code);
        rscl_cfg_t c;
        c = '0;
        case (code)
            RSCL_M_10_HALF:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_0000;
                c.crs_on_tx = 1'b1;
            end
            RSCL_M_10_FULL:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_0001;
            end
            RSCL_M_100_HALF:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_1000;
                c.crs_on_tx = 1'b1;
            end
            RSCL_M_100_FULL:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_1001;
            end
            RSCL_M_AN_100H:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_1100;
                c.advertise = RSCL_A_0100;
                c.crs_on_tx = 1'b1;
            end
            RSCL_M_REPEATER:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_1100;
                c.advertise = RSCL_A_0100;
                c.repeater = 1'b1;
            end
            RSCL_M_PDOWN: c.power_down = 1'b1;
            default:
            begin
                {c.speed_100, c.an_enable, c.bit10, c.full_duplex} =
                    RSCL_C_X10X;
                c.advertise = RSCL_A_1111;
                c.crs_on_tx = 1'b1;
            end
        endcase
        return c;
    endfunction

    // Merges bus write data into an old word under the byte strobes.
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Tells whether a byte address falls on one of the four registers.
    function automatic logic addr_mapped(input logic [31:0] a);
        return (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
    endfunction

    // Either reset source holds the strap capture open.
    assign in_reset = sys_rst | ~hard_reset_n;
    assign strap_cfg = mode_decode(strap_mode_q);

    // Reset phase tracking; the release phase lasts exactly one cycle.
    always_ff @(posedge mclk)
    begin
        if (in_reset)
        begin
            phase_q <= ST_RESET;
        end
        else
        begin
            case (phase_q)
                ST_RESET: phase_q <= ST_RELEASE;
                ST_RELEASE: phase_q <= ST_RUN;
                ST_RUN: phase_q <= ST_RUN;
                default: phase_q <= ST_RESET;
            endcase
        end
    end

    // Straps follow the pins only while a reset is held, so the value kept is
    // the one present as reset rises; later pin traffic is ignored.
    always_ff @(posedge mclk)
    begin
        if (in_reset)
        begin
            strap_mode_q <= mode_pin_in;
            strap_rmii_q <= reduced_if_select_strap;
        end
    end

    // The regulator strap is taken once per power-on, only after the supplies
    // are good, since an early sample could catch a pin still charging.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            por_pend_q <= 1'b1;
            reg_off_q <= 1'b0;
        end
        else if (por_pend_q && supplies_valid)
        begin
            por_pend_q <= 1'b0;
            reg_off_q <= core_regulator_off_strap;
        end
    end

    assign core_regulator_en = ~por_pend_q & ~reg_off_q;

    // Shared pins are released during reset so the straps can be read, then
    // carry the receive path.
    always_ff @(posedge mclk)
    begin
        if (in_reset)
        begin
            mode_pin_out <= 3'h0;
            mode_pin_oe_n <= 3'h7;
        end
        else
        begin
            mode_pin_out <= rx_func_data;
            mode_pin_oe_n <= 3'h0;
        end
    end

    // Register images as read over the bus.
    assign ctrl_word = {16'h0000, 2'h0, cfg_q.speed_100, cfg_q.an_enable,
                        cfg_q.power_down, cfg_q.bit10, 1'b0,
                        cfg_q.full_duplex, 8'h00};
    assign adv_word = {23'h000000, cfg_q.advertise, 5'h00};
    assign spc_word = {17'h00000, if_kind_q, 6'h00, spc_mode_q, 5'h00};
    assign sts_word = {24'h000000, cfg_q.repeater, cfg_q.crs_on_tx,
                       ~por_pend_q, reg_off_q, strap_rmii_q, strap_mode_q};
    assign wr_ctrl = merge_strb(ctrl_word, wdata_q, wstrb_q);
    assign wr_adv = merge_strb(adv_word, wdata_q, wstrb_q);
    assign wr_spc = merge_strb(spc_word, wdata_q, wstrb_q);
    assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;

    // Configuration: straps load at release, soft reset re-applies the
    // present registers, bus writes override in between.
    always_ff @(posedge mclk)
    begin
        if (in_reset)
        begin
            cfg_q <= '0;
            spc_mode_q <= 3'h0;
            if_kind_q <= 1'b0;
            soft_pend_q <= 1'b0;
        end
        else if (phase_q == ST_RELEASE)
        begin
            cfg_q <= strap_cfg;
            spc_mode_q <= strap_mode_q;
            if_kind_q <= strap_rmii_q;
        end
        else if (soft_pend_q)
        begin
            // Only power-down follows the mode field; the rest is kept.
            soft_pend_q <= 1'b0;
            cfg_q.power_down <= (spc_mode_q == RSCL_M_PDOWN);
        end
        else if (wr_fire)
        begin
            case (waddr_q)
                RSCL_OFS_CTRL:
                begin
                    cfg_q.speed_100 <= wr_ctrl[RSCL_CTRL_SPEED];
                    cfg_q.an_enable <= wr_ctrl[RSCL_CTRL_AN_EN];
                    cfg_q.power_down <= wr_ctrl[RSCL_CTRL_PDOWN];
                    cfg_q.bit10 <= wr_ctrl[RSCL_CTRL_BIT10];
                    cfg_q.full_duplex <= wr_ctrl[RSCL_CTRL_DUPLEX];
                    soft_pend_q <= wr_ctrl[RSCL_CTRL_SOFT_RESET];
                end
                RSCL_OFS_ADV:
                begin
                    cfg_q.advertise <= wr_adv[RSCL_ADV_LSB +: 4];
                end
                RSCL_OFS_SPECIAL:
                begin
                    spc_mode_q <= wr_spc[RSCL_SPC_MODE_LSB +: 3];
                    if_kind_q <= wr_spc[RSCL_SPC_IF_KIND];
                end
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    assign block_cfg = cfg_q;
    assign mac_if_kind_bit = if_kind_q;

    // Write address and data are taken in either order; the response waits
    // for both.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RSCL_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                waddr_q <= addr_mapped(s_axi_awaddr) ?
                           s_axi_awaddr[3:0] : 4'h1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (waddr_q == 4'h1) ?
                           RSCL_RESP_SLVERR : RSCL_RESP_OKAY;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RSCL_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= addr_mapped(s_axi_araddr) ?
                       RSCL_RESP_OKAY : RSCL_RESP_SLVERR;
            case (addr_mapped(s_axi_araddr) ? s_axi_araddr[3:0] : 4'h1)
                RSCL_OFS_CTRL: rdata_q <= ctrl_word;
                RSCL_OFS_ADV: rdata_q <= adv_word;
                RSCL_OFS_SPECIAL: rdata_q <= spc_word;
                RSCL_OFS_STRAP: rdata_q <= sts_word;
                default: rdata_q <= 32'h00000000;
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // rscl_top

// *** dv/rscl_properties.sv ***
// Port checker for rscl_top: reset loading, shared pins, bus answers.
// Assumes one clock and that straps only move while a reset is held.
`timescale 1ns/1ps

module rscl_properties
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hard_reset_n,
    input wire logic supplies_valid,
    input wire logic [2:0] mode_pin_in,
    input wire logic [2:0] mode_pin_out,
    input wire logic [2:0] mode_pin_oe_n,
    input wire logic [2:0] rx_func_data,
    input wire logic reduced_if_select_strap,
    input wire logic core_regulator_off_strap,
    input wire logic core_regulator_en,
    input wire logic mac_if_kind_bit,
    input wire rscl_pkg::rscl_cfg_t block_cfg,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid
);
    import rscl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [2:0] run_q;
    logic [1:0] sup_q;

    // Cycles since any reset; waiting seven hides the load latency.
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !hard_reset_n)
            run_q <= 3'h0;
        else if (run_q != 3'h7)
            run_q <= run_q + 3'h1;
    end

    // Cycles of good supplies since power-on, saturating at three.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            sup_q <= 2'h0;
        else if (supplies_valid && sup_q != 2'h3)
            sup_q <= sup_q + 2'h1;
    end

    property p_cfg_rst;
        !hard_reset_n |=> block_cfg == '0 && !mac_if_kind_bit;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst)
        else $error("configuration not cleared in reset");
    property p_pdown;
        $rose(hard_reset_n) && $past(mode_pin_in) == 3'h6
            |-> ##[1:3] block_cfg.power_down;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("power-down not loaded");
    property p_if_kind;
        $rose(hard_reset_n) && $past(reduced_if_select_strap)
            |-> ##[1:3] mac_if_kind_bit;
    endproperty
    a_if_kind: assert property (p_if_kind)
        else $error("interface kind not loaded");
    property p_if_hold;
        run_q == 3'h7 |-> $stable(mac_if_kind_bit);
    endproperty
    a_if_hold: assert property (p_if_hold)
        else $error("interface kind moved");
    property p_oe_rst;
        !hard_reset_n |=> mode_pin_oe_n == 3'h7 && mode_pin_out == 3'h0;
    endproperty
    a_oe_rst: assert property (p_oe_rst)
        else $error("shared pins not released");
    property p_pin_drive;
        run_q == 3'h7 |-> mode_pin_oe_n == 3'h0
            && mode_pin_out == $past(rx_func_data);
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("shared pins not carrying receive data");
    property p_reg;
        sup_q == 2'h3 |-> core_regulator_en == !core_regulator_off_strap;
    endproperty
    a_reg: assert property (p_reg)
        else $error("regulator state wrong");
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write not answered");

    c_pdown: cover property ($rose(block_cfg.power_down));
    c_rmii: cover property ($rose(mac_if_kind_bit));
    c_reg_off: cover property (sup_q == 2'h3 && !core_regulator_en);
endmodule // rscl_properties

// *** dv/rscl_pin_net.sv ***
// Shared receive pins: strap resistors set the level while released.
// Assumes the device drives a pin only when its enable is low.
`timescale 1ns/1ps

module rscl_pin_net
(
    input wire logic [2:0] strap,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    output logic [2:0] pin
);
    // A driven pin shows the device, a released one its resistor.
    assign pin = (pin_oe_n & strap) | (~pin_oe_n & pin_out);
endmodule // rscl_pin_net

// *** dv/testbench.sv ***
// Self-checking bench for rscl_top with an AXI4-Lite master.
// Assumes the pin network model and checker are compiled first.
`timescale 1ns/1ps

module testbench;
    import rscl_pkg::*;
    logic mclk, sys_rst, hard_reset_n, supplies_valid;
    logic [2:0] mode_pin_in, mode_pin_out, mode_pin_oe_n, rx_func_data;
    logic [2:0] strap;
    logic reduced_if_select_strap, core_regulator_off_strap;
    logic core_regulator_en, mac_if_kind_bit;
    rscl_cfg_t block_cfg;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] d;
    int failures, checked, cycles;
    // Expected configuration per mode code, packed as rscl_cfg_t.
    logic [10:0] exp_cfg [8] = '{11'h002, 11'h080, 11'h402, 11'h480,
                                 11'h612, 11'h611, 11'h040, 11'h6BE};

    rscl_top i_dut (.mclk, .sys_rst, .hard_reset_n, .supplies_valid,
        .mode_pin_in, .mode_pin_out, .mode_pin_oe_n, .rx_func_data,
        .reduced_if_select_strap, .core_regulator_off_strap,
        .core_regulator_en, .mac_if_kind_bit, .block_cfg, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rscl_pin_net i_net (.strap, .pin_out(mode_pin_out),
        .pin_oe_n(mode_pin_oe_n), .pin(mode_pin_in));

    // Clock, moving receive data, and a cycle ceiling against hangs.
    always #10 mclk = ~mclk;
    always @(posedge mclk)
    begin
        rx_func_data <= rx_func_data + 3'h1;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Each channel is dropped at the edge that takes it; no fixed wait.
    task automatic wr(input logic [31:0] a, input logic [31:0] wd,
                      output logic [1:0] rsp);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] rdv,
                      output logic [1:0] rsp);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic por(input logic off, input logic sv, input logic [2:0] c);
        @(posedge mclk);
        sys_rst <= 1'b1;
        supplies_valid <= sv;
        core_regulator_off_strap <= off;
        strap <= c;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic hrst(input logic [2:0] c, input logic rmii);
        @(posedge mclk);
        hard_reset_n <= 1'b0;
        strap <= c;
        reduced_if_select_strap <= rmii;
        repeat (3) @(posedge mclk);
        hard_reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    // Every mode code through the hardware reset pin.
    task automatic t_modes();
        for (int c = 0; c < 8; c++)
        begin
            hrst(c[2:0], c[0]);
            cmp(32'(block_cfg), 32'(exp_cfg[c]));
            cmp(32'(mac_if_kind_bit), 32'(c[0]));
            rd(32'(RSCL_OFS_CTRL), d, r);
            cmp(d & 32'h3D00, {18'h0, exp_cfg[c][10:9], exp_cfg[c][6],
                exp_cfg[c][8], 1'b0, exp_cfg[c][7], 8'h00});
            rd(32'(RSCL_OFS_ADV), d, r);
            cmp(d & 32'h1E0, {23'h0, exp_cfg[c][5:2], 5'h0});
            rd(32'(RSCL_OFS_SPECIAL), d, r);
            cmp(d & 32'h40E0, {17'h0, c[0], 6'h0, c[2:0], 5'h0});
        end
    endtask

    // Leaving strap power-down by mode field and soft reset, then back.
    task automatic t_soft();
        hrst(3'h6, 1'b1);
        wr(32'(RSCL_OFS_CTRL), 32'h2900, r);
        repeat (2) @(posedge mclk);
        cmp(32'(block_cfg), 32'h4C0);
        rd(32'(RSCL_OFS_SPECIAL), d, r);
        wr(32'(RSCL_OFS_SPECIAL), d & ~32'hE0, r);
        wr(32'(RSCL_OFS_CTRL), 32'hA900, r);
        repeat (2) @(posedge mclk);
        cmp(32'(block_cfg), 32'h480);
        cmp(32'(mac_if_kind_bit), 32'h1);
        rd(32'(RSCL_OFS_SPECIAL), d, r);
        wr(32'(RSCL_OFS_SPECIAL), d | 32'hC0, r);
        wr(32'(RSCL_OFS_CTRL), 32'hA100, r);
        repeat (2) @(posedge mclk);
        cmp(32'(block_cfg), 32'h4C0);
    endtask

    // Unmapped, unaligned and read-only places.
    task automatic t_bus();
        rd(32'h10, d, r);
        cmp({30'h0, r}, 32'(RSCL_RESP_SLVERR));
        cmp(d, 32'h0);
        wr(32'h2, 32'h1, r);
        cmp({30'h0, r}, 32'(RSCL_RESP_SLVERR));
        wr(32'(RSCL_OFS_STRAP), 32'hFFFFFFFF, r);
        cmp({30'h0, r}, 32'(RSCL_RESP_OKAY));
        rd(32'(RSCL_OFS_STRAP), d, r);
        cmp(d & 32'h3F, 32'h2E);
    endtask

    // Regulator strap waits for good supplies at power-on.
    task automatic t_reg();
        por(1'b1, 1'b0, 3'h3);
        cmp(32'(core_regulator_en), 32'h0);
        cmp(32'(block_cfg), 32'(exp_cfg[3]));
        supplies_valid <= 1'b1;
        repeat (3) @(posedge mclk);
        cmp(32'(core_regulator_en), 32'h0);
        rd(32'(RSCL_OFS_STRAP), d, r);
        cmp(d & 32'h30, 32'h30);
        por(1'b0, 1'b1, 3'h3);
        cmp(32'(core_regulator_en), 32'h1);
    endtask

    // Inputs get values at time zero, then the scenarios run in turn.
    initial
    begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        hard_reset_n = 1'b1;
        supplies_valid = 1'b1;
        strap = 3'h0;
        rx_func_data = 3'h0;
        reduced_if_select_strap = 1'b0;
        core_regulator_off_strap = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        failures = 0;
        checked = 0;
        cycles = 0;
        por(1'b0, 1'b1, 3'h0);
        t_modes();
        t_soft();
        t_bus();
        t_reg();
        end_of_test();
    end
endmodule // testbench

bind rscl_top rscl_properties i_chk (.mclk, .sys_rst, .hard_reset_n,
    .supplies_valid, .mode_pin_in, .mode_pin_out, .mode_pin_oe_n,
    .rx_func_data, .reduced_if_select_strap, .core_regulator_off_strap,
    .core_regulator_en, .mac_if_kind_bit, .block_cfg, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
